// ### rtl/lsc_defs.vh
// constants for the link statistics counter bank
// assumes inclusion by rtl/lsc_counters.v only
`ifndef LSC_DEFS_VH
`define LSC_DEFS_VH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define LSC_OFF_TXTMO 8'h1C
`define LSC_OFF_MSGEX 8'h24
`define LSC_OFF_DATEX 8'h28
`define LSC_OFF_ENDOP 8'h2C
`define LSC_OFF_TXFAIL 8'h34
`define LSC_OFF_UNDR 8'h38
`define LSC_OFF_SKIP 8'h3C
`define LSC_OFF_RXHDR 8'h40
`define LSC_OFF_RXMSG 8'h44
`define LSC_OFF_RXDAT 8'h48
`define LSC_OFF_RXRSP 8'h4C
`define LSC_OFF_RXRTH 8'h50
`define LSC_OFF_CTRL 8'h80
`define LSC_OFF_ISTAT 8'h84
`define LSC_OFF_IEN 8'h88
`define LSC_OFF_ICLR 8'h8C
// ---------------------------------------------------------------
// header function codes
// ---------------------------------------------------------------
`define LSC_FN_ENDOP 8'h05
`define LSC_FN_ABORT 8'h13
`define LSC_FN_MSG_LO 8'h08
`define LSC_FN_MSG_HI 8'h0D
`define LSC_FN_MSG_ONE 8'h06
`define LSC_FN_DAT_A 8'h0E
`define LSC_FN_DAT_B 8'h0F
`define LSC_FN_RMSG_LO 8'h28
`define LSC_FN_RMSG_HI 8'h2D
`define LSC_FN_RMSG_ONE 8'h26
`define LSC_FN_RDAT_A 8'h2E
`define LSC_FN_RDAT_B 8'h2F
`define LSC_RSP_BIT 2
// ---------------------------------------------------------------
// control and interrupt layout
// ---------------------------------------------------------------
`define LSC_CTRL_NOACK 0
`define LSC_NUM_CNT 12
`define LSC_CTRL_RST 1'b0
// deadman timeout plus one second, in ms
`define LSC_EXTRA_MS 1000
`define LSC_CLK_KHZ 20000
`endif

// ### rtl/lsc_counters.v
// link statistics counter bank with sequence timer and abort control
// assumes frame engine pulses are one cycle, synchronous to ref_clk
`timescale 1ns/10ps
`include "lsc_defs.vh"
module lsc_counters #(
   parameter CW = 32,
   parameter [31:0] DEADMAN_MS = 32'd1000,
   parameter [31:0] TX_CLK_CYCLES = 32'd20000
)(
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // register port
   input wire [7:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   output reg [31:0] regRdData,
   // transmit events from frame engine
   input wire seqStart,
   input wire bgContinue,
   input wire seqEnd,
   input wire txFrameStart,
   input wire txFrameDone,
   input wire [7:0] txFunc,
   input wire retryExhausted,
   input wire [7:0] retryFunc,
   input wire dataUnderrun,
   input wire lineLost,
   // receive events
   input wire rxFrameGood,
   input wire rxHeaderOnly,
   input wire rxRetrans,
   input wire [7:0] rxFunc,
   // actions toward frame engine
   output reg sendAbort,
   output reg discardData,
   output reg abandonFrame,
   output reg markSent,
   // interrupt
   output wire irq
);
   // ------------------------------------------------------------
   // derived timing
   // ------------------------------------------------------------
   // tick count of the full sequence span
   localparam [47:0] SEQ_CYCLES = (48'd0 + DEADMAN_MS + `LSC_EXTRA_MS)
      * `LSC_CLK_KHZ;
   localparam N = `LSC_NUM_CNT;

   // ------------------------------------------------------------
   // classification helpers
   // ------------------------------------------------------------
   // first-transmission message codes
   function isMsg;
      input [7:0] f;
      begin
         isMsg = (f == `LSC_FN_MSG_ONE) ||
            (f >= `LSC_FN_MSG_LO && f <= `LSC_FN_MSG_HI);
      end
   endfunction

   // retransmitted message codes carry the retry bit
   function isRMsg;
      input [7:0] f;
      begin
         isRMsg = (f == `LSC_FN_RMSG_ONE) ||
            (f >= `LSC_FN_RMSG_LO && f <= `LSC_FN_RMSG_HI);
      end
   endfunction

   // retransmitted associated-data codes
   function isRDat;
      input [7:0] f;
      begin
         isRDat = (f == `LSC_FN_RDAT_A) || (f == `LSC_FN_RDAT_B);
      end
   endfunction

   // first-transmission associated-data codes
   function isDat;
      input [7:0] f;
      begin
         isDat = (f == `LSC_FN_DAT_A) || (f == `LSC_FN_DAT_B);
      end
   endfunction

   // write strobe aimed at one register offset
   function wrHit;
      input stb;
      input [7:0] a;
      input [7:0] off;
      begin
         wrHit = stb && (a == off);
      end
   endfunction

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   reg noAck_ff;
   // link profile: acknowledged or non-acknowledged operation
   always @(posedge ref_clk)
   begin
      if (reset)
         noAck_ff <= `LSC_CTRL_RST;
      else if (wrHit(regWrStb, regAddr, `LSC_OFF_CTRL))
         noAck_ff <= regWrData[`LSC_CTRL_NOACK];
   end

   // ------------------------------------------------------------
   // sequence timer
   // ------------------------------------------------------------
   // 48 bits: the span reaches tens of millions of cycles
   reg [47:0] seqCnt_ff;
   reg seqRun_ff;
   wire seqExpire = seqRun_ff && (seqCnt_ff == SEQ_CYCLES - 48'd1);
   // restarts on each continuation from the background processor
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         seqRun_ff <= 1'b0;
         seqCnt_ff <= 48'h0;
      end
      else if (seqStart || bgContinue)
      begin
         seqRun_ff <= 1'b1;
         seqCnt_ff <= 48'h0;
      end
      else if (seqEnd || seqExpire)
      begin
         seqRun_ff <= 1'b0;
         seqCnt_ff <= 48'h0;
      end
      else if (seqRun_ff)
         seqCnt_ff <= seqCnt_ff + 48'd1;
   end

   // ------------------------------------------------------------
   // frame transmit timer
   // ------------------------------------------------------------
   // frame_transmit_timer: runs from frame start to done, underrun or expiry
   reg [31:0] frmCnt_ff;
   reg frmRun_ff;
   wire frmExpire = frmRun_ff && (frmCnt_ff == TX_CLK_CYCLES - 32'd1);
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         frmRun_ff <= 1'b0;
         frmCnt_ff <= 32'h0;
      end
      else if (txFrameStart)
      begin
         frmRun_ff <= 1'b1;
         frmCnt_ff <= 32'h0;
      end
      else if (txFrameDone || frmExpire || dataUnderrun)
      begin
         frmRun_ff <= 1'b0;
         frmCnt_ff <= 32'h0;
      end
      else if (frmRun_ff)
         frmCnt_ff <= frmCnt_ff + 32'd1;
   end

   // ------------------------------------------------------------
   // event qualification
   // ------------------------------------------------------------
   wire exMsg = retryExhausted && !noAck_ff && isRMsg(retryFunc);
   wire exDat = retryExhausted && !noAck_ff && isRDat(retryFunc);
   wire skip = lineLost && !frmRun_ff;
   wire hdrGood = rxFrameGood && rxHeaderOnly;
   // good first-time frame of any kind
   wire rxFirst = rxFrameGood && !rxRetrans;
   reg [N-1:0] ev;
   // one strobe per counter, bit k feeds counter k and status bit k
   always @*
   begin
      ev = {N{1'b0}};
      // background processor never continued or ended the sequence
      ev[0] = seqExpire;
      // message and data retries are dead in non-acknowledged mode
      ev[1] = exMsg;
      ev[2] = exDat;
      // only the end operation code counts here
      ev[3] = txFrameDone && txFunc == `LSC_FN_ENDOP;
      // a completion in the expiry cycle still wins
      ev[4] = frmExpire && !txFrameDone;
      // an underrun outside a frame has nothing to terminate
      ev[5] = dataUnderrun && frmRun_ff;
      // loss of line sync or clock before the frame started
      ev[6] = skip;
      // receive side: first-time header-only frames
      ev[7] = hdrGood && !rxRetrans;
      // first-time messages open a new link sequence
      ev[8] = rxFirst && isMsg(rxFunc);
      // first-time associated data, either code
      ev[9] = rxFirst && isDat(rxFunc);
      // response flag counts whether or not the frame is a retry
      ev[10] = hdrGood && rxFunc[`LSC_RSP_BIT];
      // retried end operation headers exist only with acknowledgment
      ev[11] = hdrGood && rxRetrans && !noAck_ff &&
         rxFunc == `LSC_FN_ENDOP;
   end

   // ------------------------------------------------------------
   // counters
   // ------------------------------------------------------------
   reg [CW-1:0] cnt_ff [0:N-1];
   integer i;
   // wrap at all ones; no side effect on read
   always @(posedge ref_clk)
   begin
      for (i = 0; i < N; i = i + 1)
      begin
         if (reset)
            cnt_ff[i] <= {CW{1'b0}};
         else if (ev[i])
            cnt_ff[i] <= cnt_ff[i] + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // ------------------------------------------------------------
   // actions toward frame engine
   // ------------------------------------------------------------
   // abort frame 13 ends the sequence after a message or data retry exhaustion in acknowledged mode
   always @(posedge ref_clk)
   begin
      if (reset)
         sendAbort <= 1'b0;
      else
         sendAbort <= exMsg || exDat;
   end

   // data of the failed sequence is dropped along with the abort
   always @(posedge ref_clk)
   begin
      if (reset)
         discardData <= 1'b0;
      else
         discardData <= exMsg || exDat;
   end

   // timer expiry or underrun kills the frame in flight
   always @(posedge ref_clk)
   begin
      if (reset)
         abandonFrame <= 1'b0;
      else
         abandonFrame <= ev[4] || ev[5];
   end

   // skipped frame goes on to no-response handling as if sent
   always @(posedge ref_clk)
   begin
      if (reset)
         markSent <= 1'b0;
      else
         markSent <= skip;
   end

   // ------------------------------------------------------------
   // interrupt status, enable, clear
   // ------------------------------------------------------------
   reg [N-1:0] iStat_ff;
   reg [N-1:0] iEn_ff;
   wire [N-1:0] clrMask = wrHit(regWrStb, regAddr, `LSC_OFF_ICLR) ?
      regWrData[N-1:0] : {N{1'b0}};
   // set wins over a clear in the same cycle, so no event is lost
   always @(posedge ref_clk)
   begin
      if (reset)
         iStat_ff <= {N{1'b0}};
      else
         iStat_ff <= (iStat_ff & ~clrMask) | ev;
   end

   // enable mask, same bit layout as the status register
   always @(posedge ref_clk)
   begin
      if (reset)
         iEn_ff <= {N{1'b0}};
      else if (wrHit(regWrStb, regAddr, `LSC_OFF_IEN))
         iEn_ff <= regWrData[N-1:0];
   end
   assign irq = |(iStat_ff & iEn_ff);

   // ------------------------------------------------------------
   // read decode
   // ------------------------------------------------------------
   reg [31:0] nxt_rd;
   // unmapped and write-only offsets read as zero
   always @*
   begin
      nxt_rd = 32'h0;
      // tx_sequence_timeout_count
      if (regAddr == `LSC_OFF_TXTMO)
         nxt_rd = cnt_ff[0];
      // msg_retry_exhausted_count
      else if (regAddr == `LSC_OFF_MSGEX)
         nxt_rd = cnt_ff[1];
      // data_retry_exhausted_count
      else if (regAddr == `LSC_OFF_DATEX)
         nxt_rd = cnt_ff[2];
      // end_op_sent_count
      else if (regAddr == `LSC_OFF_ENDOP)
         nxt_rd = cnt_ff[3];
      // tx_abort_count
      else if (regAddr == `LSC_OFF_TXFAIL)
         nxt_rd = cnt_ff[4];
      // tx_underrun_count
      else if (regAddr == `LSC_OFF_UNDR)
         nxt_rd = cnt_ff[5];
      // tx_skipped_count
      else if (regAddr == `LSC_OFF_SKIP)
         nxt_rd = cnt_ff[6];
      // rx_header_count
      else if (regAddr == `LSC_OFF_RXHDR)
         nxt_rd = cnt_ff[7];
      // rx_message_count
      else if (regAddr == `LSC_OFF_RXMSG)
         nxt_rd = cnt_ff[8];
      // rx_data_frame_count
      else if (regAddr == `LSC_OFF_RXDAT)
         nxt_rd = cnt_ff[9];
      // rx_response_count
      else if (regAddr == `LSC_OFF_RXRSP)
         nxt_rd = cnt_ff[10];
      // rx_retried_header_count
      else if (regAddr == `LSC_OFF_RXRTH)
         nxt_rd = cnt_ff[11];
      else if (regAddr == `LSC_OFF_CTRL)
         nxt_rd = {31'h0, noAck_ff};
      else if (regAddr == `LSC_OFF_ISTAT)
         nxt_rd = {20'h0, iStat_ff};
      else if (regAddr == `LSC_OFF_IEN)
         nxt_rd = {20'h0, iEn_ff};
   end

   // read data valid only in the cycle after the strobe
   always @(posedge ref_clk)
   begin
      if (reset)
         regRdData <= 32'h0;
      else if (regRdStb)
         regRdData <= nxt_rd;
      else
         regRdData <= 32'h0;
   end
endmodule

// ### test/lsc_counters_props.sv
// checker for the link statistics counter bank, port-level relations
// assumes bind onto lsc_counters, one clock domain
`timescale 1ns/10ps
module lsc_counters_props(
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // register port
   input wire [7:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   input wire [31:0] regRdData,
   // events
   input wire retryExhausted,
   input wire [7:0] retryFunc,
   input wire txFrameDone,
   input wire lineLost,
   // actions and interrupt
   input wire sendAbort,
   input wire discardData,
   input wire abandonFrame,
   input wire markSent,
   input wire irq
);
   // ------------------------------------------------------------
   // shadows of mode and enable, which are not visible as ports
   // ------------------------------------------------------------
   reg noAckFf;
   reg ienZeroFf;
   wire exFn = retryFunc == 8'h26 ||
      (retryFunc >= 8'h28 && retryFunc <= 8'h2F);
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         noAckFf <= 1'b0;
         ienZeroFf <= 1'b1;
      end
      else if (regWrStb && regAddr == 8'h80)
         noAckFf <= regWrData[0];
      else if (regWrStb && regAddr == 8'h88)
         ienZeroFf <= regWrData[11:0] == 12'h000;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_EXHAUST: assert property (
      retryExhausted && !noAckFf && exFn |=> sendAbort && discardData)
      else $error("no abort after retry exhaustion");
   AST_NOACK: assert property (
      noAckFf && $past(noAckFf) |-> !sendAbort)
      else $error("abort sent in non-acknowledged mode");
   AST_ABORT_CAUSE: assert property (
      sendAbort |-> $past(retryExhausted))
      else $error("abort without retry exhaustion");
   AST_ABORT_PULSE: assert property (sendAbort |=> !sendAbort)
      else $error("abort pulse longer than one cycle");
   AST_DISCARD: assert property (discardData |-> sendAbort)
      else $error("discard without abort");
   AST_RD_IDLE: assert property (
      !$past(regRdStb) |-> regRdData == 32'h0000_0000)
      else $error("read data outside read slot");
   AST_SKIP: assert property (markSent |-> $past(lineLost))
      else $error("frame marked sent without line loss");
   AST_ABANDON: assert property (
      abandonFrame |-> !$past(txFrameDone))
      else $error("frame abandoned after completing");
   AST_IRQ_OFF: assert property (ienZeroFf |-> !irq)
      else $error("interrupt with all sources disabled");
endmodule
bind lsc_counters lsc_counters_props u_lsc_counters_props(
   .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
   .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
   .regRdData(regRdData), .retryExhausted(retryExhausted),
   .retryFunc(retryFunc), .txFrameDone(txFrameDone), .lineLost(lineLost),
   .sendAbort(sendAbort), .discardData(discardData),
   .abandonFrame(abandonFrame), .markSent(markSent), .irq(irq));

// ### test/lsc_frame_engine.sv
// frame engine model: raises one-cycle event pulses on request
// assumes the bench calls ev() from one process only
`timescale 1ns/10ps
module lsc_frame_engine(
   // clock
   input wire ref_clk,
   // actions from the counter bank
   input wire sendAbort,
   // event pulses, bit k of hitFf is event kind k
   output reg [10:0] hitFf,
   output reg [7:0] fnFf
);
   reg seqLiveFf;
   initial
   begin
      hitFf = 11'h000;
      fnFf = 8'h00;
      seqLiveFf = 1'b0;
   end
   // remote side drops the failed sequence on an abort frame
   always @(posedge ref_clk)
   begin
      if (sendAbort)
         seqLiveFf <= 1'b0;
      else if (hitFf[8])
         seqLiveFf <= 1'b1;
   end
   // one pulse, then a quiet cycle so pulses never merge
   task ev(input [3:0] k, input [7:0] fn);
      begin
         @(posedge ref_clk);
         hitFf <= 11'h001 << k;
         fnFf <= fn;
         @(posedge ref_clk);
         hitFf <= 11'h000;
      end
   endtask
endmodule

// ### test/lsc_counters_bench.sv
// self-checking bench for the link statistics counter bank
// assumes lsc_frame_engine model and the bound checker
`timescale 1ns/10ps
module lsc_counters_bench;
   reg ref_clk = 1'b0;
   reg reset = 1'b1;
   reg [7:0] regAddr = 8'h00;
   reg [31:0] regWrData = 32'h0000_0000;
   reg regWrStb = 1'b0;
   reg regRdStb = 1'b0;
   wire [31:0] regRdData;
   wire [10:0] hit;
   wire [7:0] fn;
   wire sendAbort, discardData, abandonFrame, markSent, irq;
   integer n_errors = 0;
   integer n_tests = 0;
   integer i;
   reg [7:0] offs [0:11] = '{8'h1C, 8'h24, 8'h28, 8'h2C, 8'h34, 8'h38,
      8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50};
   reg [7:0] msgFn [0:6] = '{8'h26, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D};
   reg [7:0] rxFn [0:6] = '{8'h06, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
   initial forever #25 ref_clk = ~ref_clk;
   // ------------------------------------------------------------
   // design and frame engine model
   // ------------------------------------------------------------
   lsc_counters #(.TX_CLK_CYCLES(32'd16)) u_lsc_counters(
      .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .seqStart(hit[8]), .bgContinue(hit[9]),
      .seqEnd(hit[10]), .txFrameStart(hit[2]), .txFrameDone(hit[1]),
      .txFunc(fn), .retryExhausted(hit[0]), .retryFunc(fn),
      .dataUnderrun(hit[3]), .lineLost(hit[4]),
      .rxFrameGood(hit[5] | hit[6] | hit[7]),
      .rxHeaderOnly(hit[5] | hit[6]), .rxRetrans(hit[6]), .rxFunc(fn),
      .sendAbort(sendAbort), .discardData(discardData),
      .abandonFrame(abandonFrame), .markSent(markSent), .irq(irq));
   lsc_frame_engine u_lsc_frame_engine(.ref_clk(ref_clk),
      .sendAbort(sendAbort), .hitFf(hit), .fnFf(fn));
   // ------------------------------------------------------------
   // register access and comparison
   // ------------------------------------------------------------
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e)
         begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge ref_clk);
         regAddr <= a;
         regWrData <= d;
         regWrStb <= 1'b1;
         @(posedge ref_clk);
         regWrStb <= 1'b0;
      end
   endtask
   // data stands only in the cycle after the strobe
   task rd(input [7:0] a, input [31:0] e);
      begin
         @(posedge ref_clk);
         regAddr <= a;
         regRdStb <= 1'b1;
         @(posedge ref_clk);
         regRdStb <= 1'b0;
         #1;
         chk($sformatf("reg %h", a), e, regRdData);
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // hang guard, far beyond the fewer than two hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_errors = n_errors + 1;
      tally_and_finish;
   end
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      for (i = 0; i < 12; i = i + 1)
         rd(offs[i], 32'h0000_0000);
      rd(8'h00, 32'h0000_0000);
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0000_0000);
      $display("test reset and access done");
      wr(8'h88, 32'h0000_0FFF);
      for (i = 0; i < 7; i = i + 1)
         u_lsc_frame_engine.ev(4'h0, msgFn[i]);
      u_lsc_frame_engine.ev(4'h0, 8'h27);
      u_lsc_frame_engine.ev(4'h0, 8'h2E);
      u_lsc_frame_engine.ev(4'h0, 8'h2F);
      rd(8'h24, 32'h0000_0007);
      rd(8'h28, 32'h0000_0002);
      rd(8'h84, 32'h0000_0006);
      chk("irq", 32'h1, {31'h0, irq});
      wr(8'h8C, 32'h0000_0FFF);
      @(negedge ref_clk);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test retry exhaustion done");
      u_lsc_frame_engine.ev(4'h5, 8'h05);
      u_lsc_frame_engine.ev(4'h5, 8'h01);
      for (i = 0; i < 7; i = i + 1)
         u_lsc_frame_engine.ev(4'h7, rxFn[i]);
      u_lsc_frame_engine.ev(4'h7, 8'h0E);
      u_lsc_frame_engine.ev(4'h7, 8'h0F);
      rd(8'h40, 32'h0000_0002);
      rd(8'h4C, 32'h0000_0001);
      rd(8'h44, 32'h0000_0007);
      rd(8'h48, 32'h0000_0002);
      $display("test receive done");
      wr(8'h80, 32'h0000_0001);
      u_lsc_frame_engine.ev(4'h0, 8'h26);
      u_lsc_frame_engine.ev(4'h6, 8'h05);
      rd(8'h24, 32'h0000_0007);
      rd(8'h50, 32'h0000_0000);
      wr(8'h80, 32'h0000_0000);
      u_lsc_frame_engine.ev(4'h6, 8'h05);
      rd(8'h50, 32'h0000_0001);
      rd(8'h40, 32'h0000_0002);
      $display("test acknowledge mode done");
      u_lsc_frame_engine.ev(4'h8, 8'h00);
      u_lsc_frame_engine.ev(4'h1, 8'h05);
      u_lsc_frame_engine.ev(4'h1, 8'h06);
      u_lsc_frame_engine.ev(4'hA, 8'h00);
      rd(8'h2C, 32'h0000_0001);
      u_lsc_frame_engine.ev(4'h2, 8'h00);
      repeat (24) @(posedge ref_clk);
      rd(8'h34, 32'h0000_0001);
      u_lsc_frame_engine.ev(4'h2, 8'h00);
      u_lsc_frame_engine.ev(4'h3, 8'h00);
      u_lsc_frame_engine.ev(4'h3, 8'h00);
      u_lsc_frame_engine.ev(4'h4, 8'h00);
      rd(8'h38, 32'h0000_0001);
      rd(8'h34, 32'h0000_0001);
      rd(8'h3C, 32'h0000_0001);
      $display("test transmit faults done");
      tally_and_finish;
   end
endmodule
